// ---- verilog/stepper_regs_pkg.sv ----
package stepper_regs_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_DOG_CTRL   = 5'h00;
	localparam logic [4:0] ADDR_STEP_CTRL  = 5'h01;
	localparam logic [4:0] ADDR_DRIVE_CTRL = 5'h02;
	localparam logic [4:0] ADDR_OUT_CTRL   = 5'h03;
	localparam logic [4:0] ADDR_FAULT      = 5'h04;
	localparam logic [4:0] ADDR_XOVC       = 5'h05;
	localparam logic [4:0] ADDR_YOVC       = 5'h06;
	localparam logic [4:0] ADDR_POS        = 5'h07;
	localparam logic [4:0] ADDR_PWM_CTRL   = 5'h08;

	// Control registers are stored by index
	localparam int         CTRL_COUNT = 5;
	localparam logic [2:0] IDX_DOG    = 3'h0;
	localparam logic [2:0] IDX_STEP   = 3'h1;
	localparam logic [2:0] IDX_DRIVE  = 3'h2;
	localparam logic [2:0] IDX_OUT    = 3'h3;
	localparam logic [2:0] IDX_PWM    = 3'h4;

	// ------------------------------------------------------------
	// Frame format and reset values
	// ------------------------------------------------------------
	localparam int         CMD_WRITE_BIT    = 15;     // Within 16-bit frame
	localparam logic [4:0] WRITE_FRAME_BITS = 5'h10;  // 16 bits exactly
	localparam logic [4:0] FRAME_CNT_MAX    = 5'h1f;
	localparam logic [4:0] FIRST_BYTE_END   = 5'h08;
	localparam logic [2:0] BYTE_LAST        = 3'h7;
	localparam logic [7:0] CTRL_RESET       = 8'h00;
	localparam logic [7:0] STATUS_RESET     = 8'h00;

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int DOG_EN_BIT     = 7;
	localparam int DOG_TIME_LSB   = 3;
	localparam int STEP_RES_LSB   = 5;
	localparam int CUR_LSB        = 0;
	localparam int DIR_BIT        = 7;
	localparam int NXT_POL_BIT    = 6;
	localparam int PWM_DOUBLE_BIT = 3;
	localparam int PWM_JITTER_BIT = 2;
	localparam int SLOPE_LSB      = 0;
	localparam int MOT_EN_BIT     = 7;
	localparam int SLEEP_BIT      = 6;
	localparam int GAIN_BIT       = 5;
	localparam int HOLD_BIT       = 4;
	localparam int PWM_MODE_LSB   = 6;
	localparam int MASK_LSB       = 4;
	localparam int DUTY_BIT       = 2;
	localparam int COMP_LSB       = 0;

	// ------------------------------------------------------------
	// Decoded timing, duty and step values
	// ------------------------------------------------------------
	localparam logic [4:0] CYC_4  = 5'h04;
	localparam logic [4:0] CYC_8  = 5'h08;
	localparam logic [4:0] CYC_12 = 5'h0c;
	localparam logic [4:0] CYC_19 = 5'h13;
	localparam logic [6:0] DUTY_PCT_WIDE   = 7'h56;  // 86 %
	localparam logic [6:0] DUTY_PCT_NARROW = 7'h4b;  // 75 %
	localparam logic [5:0] DIV_32 = 6'h20;
	localparam logic [5:0] DIV_16 = 6'h10;
	localparam logic [5:0] DIV_8  = 6'h08;
	localparam logic [5:0] DIV_4  = 6'h04;
	localparam logic [5:0] DIV_2  = 6'h02;
	localparam logic [5:0] DIV_1  = 6'h01;
	localparam logic [5:0] DIV_NA = 6'h00;

	// Peak current in mA for each code, 122 up to 4750
	localparam logic [12:0] PEAK_MA [32] = '{
		13'h07a, 13'h0e6, 13'h15e, 13'h172, 13'h19a, 13'h1c7, 13'h1f4, 13'h226,
		13'h267, 13'h2a8, 13'h2ee, 13'h348, 13'h394, 13'h3f2, 13'h456, 13'h4b5,
		13'h56e, 13'h5f0, 13'h690, 13'h712, 13'h7d0, 13'h875, 13'h960, 13'ha5a,
		13'hb40, 13'hc12, 13'hcfd, 13'hdf2, 13'hef1, 13'hffa, 13'h1112, 13'h128e
	};

	// Status byte: bit 7 is one when bits 6..0 hold an odd count
	function automatic logic [7:0] withParity(input logic [6:0] d);
		return {^d, d};
	endfunction : withParity

	// Maps a control address to {hit, index}
	function automatic logic [3:0] ctrlIndex(input logic [4:0] addr);
		unique case (addr)
			ADDR_DOG_CTRL:   ctrlIndex = {1'b1, IDX_DOG};
			ADDR_STEP_CTRL:  ctrlIndex = {1'b1, IDX_STEP};
			ADDR_DRIVE_CTRL: ctrlIndex = {1'b1, IDX_DRIVE};
			ADDR_OUT_CTRL:   ctrlIndex = {1'b1, IDX_OUT};
			ADDR_PWM_CTRL:   ctrlIndex = {1'b1, IDX_PWM};
			default:         ctrlIndex = 4'h0;
		endcase
	endfunction : ctrlIndex

endpackage : stepper_regs_pkg

// ---- verilog/sync_bits.sv ----
`timescale 1ns/10ps
// --------------------------------------------------------------------
// Two-flop level synchroniser
// --------------------------------------------------------------------
module sync_bits #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,   // Destination clock
	input  wire logic             nrst,  // Async reset, active low
	input  wire logic [WIDTH-1:0] d,     // Asynchronous levels
	output logic      [WIDTH-1:0] q      // Synchronised levels
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : sync_bits

// ---- verilog/stepper_reg_bank.sv ----
`timescale 1ns/10ps
// --------------------------------------------------------------------
// Serial register bank of the stepper driver
// --------------------------------------------------------------------
module stepper_reg_bank
	import stepper_regs_pkg::*;
#(
	parameter logic [4:0] MASK_CYCLES_CODE1 = 5'h08
) (
	input  wire logic        clk,                // System clock, 200 MHz
	input  wire logic        nrst,               // Async reset, active low
	input  wire logic        spiClk,             // Serial clock, mode 0
	input  wire logic        csN,                // Chip select, active low
	input  wire logic        spiDataIn,          // Serial data from master
	output logic             spiDataOut,         // Serial data to master
	output logic             spiDataOutOe,       // Drive enable for data out
	output logic             errOut,             // Error pin level, always 0
	output logic             errOe,              // Error pin pulled low
	input  wire logic        thermalWarning,     // Pin-level fault inputs
	input  wire logic        pumpFault,          // Pump below level
	input  wire logic        coilXOpen,          // Open coil X
	input  wire logic        coilYOpen,          // Open coil Y
	input  wire logic        thermalShutdown,    // Thermal shutdown event
	input  wire logic [3:0]  xOvercurrent,       // PT, PB, NT, NB
	input  wire logic [3:0]  yOvercurrent,       // PT, PB, NT, NB
	input  wire logic        dogTimeout,         // Watchdog reset pulse
	input  wire logic [6:0]  microstepPosition,  // Translator position
	input  wire logic [7:0]  angleMeasure,       // Load angle measurement
	output logic [7:0]       speedAngleOutput,   // Scaled angle output
	output logic             dogEventFlag,       // Sticky watchdog event
	output logic             dogEnable,          // Watchdog enable
	output logic [3:0]       dogTimeSel,         // Watchdog time select
	output logic [2:0]       stepResolution,     // Step mode code
	output logic [5:0]       stepDivisor,        // Micro-steps per step
	output logic             stepModeValid,      // Code is usable
	output logic             halfStepComp,       // Compensated half step
	output logic [4:0]       peakCurrentCode,    // Current code
	output logic [12:0]      peakCurrentMa,      // Current in mA
	output logic             dirReverse,         // Direction control
	output logic             nxtFallingEdge,     // Step edge polarity
	output logic             pwmDouble,          // Double PWM frequency
	output logic             pwmJitter,          // Jittered PWM
	output logic [1:0]       slopeSel,           // Output slope select
	output logic             bridgeEnable,       // Bridge outputs on
	output logic             sleepRequest,       // Sleep request
	output logic             angleGainQuarter,   // Gain 0.25 when set
	output logic             angleHold,          // Angle output held
	output logic [1:0]       pwmModeSel,         // PWM mode control
	output logic [1:0]       maskTimeSel,        // Mask time code
	output logic [4:0]       maskTimeCycles,     // Mask time, PWM clocks
	output logic             dutyLimit75,        // 75 % regulator
	output logic [6:0]       dutyLimitPercent,   // Regulator duty
	output logic [1:0]       compBridgeTimeSel,  // Compensation time code
	output logic [4:0]       compBridgeCycles    // Comp time, PWM clocks
);

	// ------------------------------------------------------------
	// Serial clock domain
	// ------------------------------------------------------------
	logic [2:0]  bitInByte_q;
	logic [4:0]  frameCnt_q;
	logic        byteDone_q;
	logic [15:0] rxShift_q;
	logic [4:0]  frameLen_q;
	logic [4:0]  curAddr_q;
	logic        prevWrite_q;
	logic [3:0]  readMask_q;
	logic [7:0]  txShift_q;
	logic [7:0]  rxByte;
	logic        byteEnd;
	logic        isCmd;
	logic [7:0]  readData;
	logic [3:0]  rdMap;

	assign rxByte  = {rxShift_q[6:0], spiDataIn};
	assign byteEnd = (bitInByte_q == BYTE_LAST);
	assign isCmd   = (frameCnt_q < FIRST_BYTE_END) || !prevWrite_q;

	// Position in frame; chip select high restarts the frame
	always_ff @(posedge spiClk or posedge csN) begin
		if (csN) begin
			bitInByte_q <= 3'h0;
			frameCnt_q  <= 5'h00;
			byteDone_q  <= 1'b0;
		end else begin
			bitInByte_q <= bitInByte_q + 3'h1;
			byteDone_q  <= byteEnd;
			if (frameCnt_q != FRAME_CNT_MAX) begin
				frameCnt_q <= frameCnt_q + 5'h01;
			end
		end
	end

	// Receive side; these hold still once chip select rises
	always_ff @(posedge spiClk or negedge nrst) begin
		if (!nrst) begin
			rxShift_q   <= 16'h0000;
			frameLen_q  <= 5'h00;
			curAddr_q   <= 5'h00;
			prevWrite_q <= 1'b0;
			readMask_q  <= 4'h0;
		end else begin
			rxShift_q  <= {rxShift_q[14:0], spiDataIn};
			frameLen_q <= (frameCnt_q == FRAME_CNT_MAX) ? FRAME_CNT_MAX :
				frameCnt_q + 5'h01;
			if (byteEnd) begin
				prevWrite_q <= isCmd && rxByte[7];
			end
			if (byteEnd && isCmd) begin
				curAddr_q <= rxByte[4:0];
			end
			// Status reads in this frame, cleared on its first edge
			if (frameCnt_q == 5'h00) begin
				readMask_q <= 4'h0;
			end else if (byteEnd && isCmd && rxByte[4:2] == 3'h1) begin
				readMask_q[rxByte[1:0]] <= 1'b1;
			end
		end
	end

	// Load on the eighth falling edge, shift on the others
	always_ff @(negedge spiClk or negedge nrst) begin
		if (!nrst) begin
			txShift_q <= 8'h00;
		end else if (byteDone_q) begin
			txShift_q <= readData;
		end else begin
			txShift_q <= {txShift_q[6:0], 1'b0};
		end
	end

	assign spiDataOut   = txShift_q[7];
	assign spiDataOutOe = !csN;

	// ------------------------------------------------------------
	// System clock domain
	// ------------------------------------------------------------
	logic [12:0] faultSync;
	logic        csSync;
	logic        csHigh;
	logic        csHighPrev_q;
	logic        csRise;
	logic [3:0]  wrMap;
	logic        wrHit;
	logic [7:0]  wrData;
	logic [7:0]  ctrl_q [CTRL_COUNT];
	logic        dogFlag_q;
	logic [3:0]  xLatch_q;
	logic [3:0]  xLatch_d;
	logic [3:0]  yLatch_q;
	logic [3:0]  yLatch_d;
	logic        tsdLatch_q;
	logic        tsdLatch_d;
	logic [7:0]  srFault_q;
	logic [7:0]  srX_q;
	logic [7:0]  srY_q;
	logic [7:0]  srPos_q;
	logic        err_q;
	logic        twSync;
	logic        pumpSync;
	logic        openXSync;
	logic        openYSync;
	logic        tsdSync;
	logic [3:0]  xOvcSync;
	logic [3:0]  yOvcSync;

	// Fault pins and chip select cross in through two flops
	sync_bits #(
		.WIDTH (14)
	) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.d    ({csN, thermalWarning, pumpFault, coilXOpen, coilYOpen,
			thermalShutdown, xOvercurrent, yOvercurrent}),
		.q    ({csSync, faultSync})
	);

	assign {twSync, pumpSync, openXSync, openYSync, tsdSync, xOvcSync,
		yOvcSync} = faultSync;
	assign csHigh = csSync;
	assign csRise = csHigh && !csHighPrev_q;

	// Frame words are stable by now: no serial edges while deselected
	assign wrMap  = ctrlIndex(rxShift_q[12:8]);
	assign wrData = rxShift_q[7:0];
	assign wrHit  = csRise && wrMap[3] && rxShift_q[CMD_WRITE_BIT] &&
		(frameLen_q == WRITE_FRAME_BITS);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			csHighPrev_q <= 1'b0;
		end else begin
			csHighPrev_q <= csHigh;
		end
	end

	// Control registers take a whole 16-bit write at deselect
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < CTRL_COUNT; i++) begin
				ctrl_q[i] <= CTRL_RESET;
			end
		end else if (wrHit) begin
			ctrl_q[wrMap[2:0]] <= wrData;
		end
	end

	// Watchdog event: set wins, only a zero enable write clears
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dogFlag_q <= 1'b0;
		end else if (dogTimeout) begin
			dogFlag_q <= 1'b1;
		end else if (wrHit && wrMap[2:0] == IDX_DOG &&
			!wrData[DOG_EN_BIT]) begin
			dogFlag_q <= 1'b0;
		end
	end

	// Over-current latches; a new event beats the read clear
	always_comb begin
		xLatch_d   = (xLatch_q & ~{4{csRise && readMask_q[1]}}) | xOvcSync;
		yLatch_d   = (yLatch_q & ~{4{csRise && readMask_q[2]}}) | yOvcSync;
		tsdLatch_d = (tsdLatch_q && !(csRise && readMask_q[2])) || tsdSync;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xLatch_q   <= 4'h0;
			yLatch_q   <= 4'h0;
			tsdLatch_q <= 1'b0;
		end else begin
			xLatch_q   <= xLatch_d;
			yLatch_q   <= yLatch_d;
			tsdLatch_q <= tsdLatch_d;
		end
	end

	// Readable status frozen while selected so a frame reads one set
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			srFault_q <= STATUS_RESET;
			srX_q     <= STATUS_RESET;
			srY_q     <= STATUS_RESET;
			srPos_q   <= STATUS_RESET;
			err_q     <= 1'b0;
		end else if (csHigh) begin
			srFault_q <= withParity({twSync, pumpSync, dogFlag_q,
				openXSync, openYSync, 2'b00});
			srX_q     <= withParity({xLatch_d, 3'b000});
			srY_q     <= withParity({yLatch_d, tsdLatch_d, 2'b00});
			srPos_q   <= withParity(microstepPosition);
			err_q     <= (|xLatch_d) || (|yLatch_d) || tsdLatch_d;
		end
	end

	assign errOut       = 1'b0;
	assign errOe        = err_q;
	assign dogEventFlag = dogFlag_q;

	// Read mux; its sources only change while the bus is deselected
	assign rdMap = ctrlIndex(curAddr_q);

	always_comb begin
		unique case (curAddr_q)
			ADDR_FAULT: readData = srFault_q;
			ADDR_XOVC:  readData = srX_q;
			ADDR_YOVC:  readData = srY_q;
			ADDR_POS:   readData = srPos_q;
			default: begin
				if (rdMap[3]) begin
					readData = ctrl_q[rdMap[2:0]];
				end else begin
					readData = 8'h00;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	assign dogEnable        = ctrl_q[IDX_DOG][DOG_EN_BIT];
	assign dogTimeSel       = ctrl_q[IDX_DOG][DOG_TIME_LSB +: 4];
	assign stepResolution   = ctrl_q[IDX_STEP][STEP_RES_LSB +: 3];
	assign peakCurrentCode  = ctrl_q[IDX_STEP][CUR_LSB +: 5];
	assign dirReverse       = ctrl_q[IDX_DRIVE][DIR_BIT];
	assign nxtFallingEdge   = ctrl_q[IDX_DRIVE][NXT_POL_BIT];
	assign pwmDouble        = ctrl_q[IDX_DRIVE][PWM_DOUBLE_BIT];
	assign pwmJitter        = ctrl_q[IDX_DRIVE][PWM_JITTER_BIT];
	assign slopeSel         = ctrl_q[IDX_DRIVE][SLOPE_LSB +: 2];
	assign bridgeEnable     = ctrl_q[IDX_OUT][MOT_EN_BIT];
	assign sleepRequest     = ctrl_q[IDX_OUT][SLEEP_BIT];
	assign angleGainQuarter = ctrl_q[IDX_OUT][GAIN_BIT];
	assign angleHold        = ctrl_q[IDX_OUT][HOLD_BIT];
	assign pwmModeSel       = ctrl_q[IDX_PWM][PWM_MODE_LSB +: 2];
	assign maskTimeSel      = ctrl_q[IDX_PWM][MASK_LSB +: 2];
	assign dutyLimit75      = ctrl_q[IDX_PWM][DUTY_BIT];
	assign compBridgeTimeSel = ctrl_q[IDX_PWM][COMP_LSB +: 2];

	// Angle output: transparent or held, halved or quartered
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			speedAngleOutput <= 8'h00;
		end else if (!angleHold) begin
			speedAngleOutput <= angleGainQuarter ? {2'b00, angleMeasure[7:2]} :
				{1'b0, angleMeasure[7:1]};
		end
	end

	// Decoded settings, registered one cycle after the field
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stepDivisor      <= DIV_32;
			stepModeValid    <= 1'b1;
			halfStepComp     <= 1'b0;
			peakCurrentMa    <= PEAK_MA[0];
			maskTimeCycles   <= CYC_4;
			compBridgeCycles <= CYC_4;
			dutyLimitPercent <= DUTY_PCT_WIDE;
		end else begin
			stepModeValid <= (stepResolution != 3'h7);
			halfStepComp  <= (stepResolution == 3'h4);
			unique case (stepResolution)
				3'h0: stepDivisor <= DIV_32;
				3'h1: stepDivisor <= DIV_16;
				3'h2: stepDivisor <= DIV_8;
				3'h3: stepDivisor <= DIV_4;
				3'h4: stepDivisor <= DIV_2;
				3'h5: stepDivisor <= DIV_2;
				3'h6: stepDivisor <= DIV_1;
				3'h7: stepDivisor <= DIV_NA;
			endcase
			peakCurrentMa <= PEAK_MA[peakCurrentCode];
			unique case (maskTimeSel)
				2'h0: maskTimeCycles <= CYC_4;
				2'h1: maskTimeCycles <= MASK_CYCLES_CODE1;
				2'h2: maskTimeCycles <= CYC_12;
				2'h3: maskTimeCycles <= CYC_19;
			endcase
			unique case (compBridgeTimeSel)
				2'h0: compBridgeCycles <= CYC_4;
				2'h1: compBridgeCycles <= CYC_8;
				2'h2: compBridgeCycles <= CYC_12;
				2'h3: compBridgeCycles <= CYC_19;
			endcase
			dutyLimitPercent <= dutyLimit75 ? DUTY_PCT_NARROW :
				DUTY_PCT_WIDE;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence s_readEnd;
		csRise && readMask_q[1] && (xOvcSync == 4'h0);
	endsequence

	sequence s_heldTwice;
		angleHold ##1 angleHold;
	endsequence

	a_angle_held: assert property (
		s_heldTwice |-> $stable(speedAngleOutput))
		else $error("angle output moved while held");
	a_angle_gain: assert property (
		!angleHold |=> speedAngleOutput == ($past(angleGainQuarter) ?
		{2'b00, $past(angleMeasure[7:2])} :
		{1'b0, $past(angleMeasure[7:1])}))
		else $error("angle output gain wrong");
	a_step_unused: assert property ((stepResolution == 3'h7) |=>
		!stepModeValid && stepDivisor == DIV_NA)
		else $error("unused step code accepted");
	a_mask_time: assert property ((maskTimeSel == 2'h3) |=>
		maskTimeCycles == CYC_19)
		else $error("mask time for code 11 wrong");
	a_status_parity: assert property (!(^srFault_q) && !(^srX_q) &&
		!(^srY_q) && !(^srPos_q))
		else $error("status parity wrong");
	a_frozen_low: assert property (!csHigh |=> $stable(srX_q) &&
		$stable(srY_q) && $stable(errOe))
		else $error("status changed while selected");
	a_dog_sets: assert property (
		dogTimeout |=> dogFlag_q ##1 dogFlag_q)
		else $error("dog event flag not set");
	a_dog_sticky: assert property (dogFlag_q && !wrHit |=> dogFlag_q)
		else $error("dog event flag cleared without write");
	a_read_clears: assert property (s_readEnd |=> xLatch_q == 4'h0 ##1
		srX_q == STATUS_RESET || !csHigh)
		else $error("x status not cleared after read");
	a_write_len: assert property (csRise && frameLen_q != WRITE_FRAME_BITS
		|=> $stable(bridgeEnable) && $stable(peakCurrentCode))
		else $error("short or long frame changed control");

endmodule : stepper_reg_bank

// ---- dv/spi_master_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Serial mode-0 master standing in for the microcontroller
// ------------------------------------------------------------
module spi_master_model (
	output logic      spiClk,     // Serial clock, still outside frames
	output logic      csN,        // Chip select, active low
	output logic      spiDataIn,  // Data towards the device
	input  wire logic spiDataOut  // Data from the device
);
	// Idle bus: deselected, clock low
	initial begin
		spiClk = 1'b0;
		csN = 1'b1;
		spiDataIn = 1'b0;
	end

	// Sends n bits MSB first, bits past 16 as zeros; rx keeps the last byte
	task automatic xfer(input logic [15:0] tx, input int n,
		output logic [7:0] rx);
		csN = 1'b0;
		#20;
		for (int i = 0; i < n; i++) begin
			spiDataIn = (i < 16) ? tx[15-i] : 1'b0;
			#16 spiClk = 1'b1;
			rx = {rx[6:0], spiDataOut};  // Sampled on rising edge
			#16 spiClk = 1'b0;
		end
		#20 csN = 1'b1;
		spiDataIn = ~spiDataIn;  // Stale level must not look valid
		#60;  // Long gap so status refresh finishes between frames
	endtask : xfer
endmodule : spi_master_model

// ---- dv/test_stepper_reg_bank.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Bench: register traffic through the serial master model
// ------------------------------------------------------------
module test_stepper_reg_bank;
	import stepper_regs_pkg::*;
	logic clk = 0, nrst = 0, dto = 0, sck, csN, sdi, sdo, errOe;
	logic dog, smv, pd, pj, be;
	logic [4:0] fl = 0, mc, cc;
	logic [3:0] xo = 0, yo = 0;
	logic [6:0] msp = 0, dp;
	logic [7:0] am = 0, sa, rd;
	logic [5:0] div;
	logic [12:0] ma;
	logic [5:0] divs [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01,
		6'h00};
	logic [4:0] cyc [4] = '{5'h04, 5'h08, 5'h0c, 5'h13};
	int num_errors = 0, check_count = 0;

	spi_master_model m (.spiClk(sck), .csN, .spiDataIn(sdi),
		.spiDataOut(sdo));
	stepper_reg_bank DUT (.clk, .nrst, .spiClk(sck), .csN, .spiDataIn(sdi),
		.spiDataOut(sdo), .spiDataOutOe(), .errOut(), .errOe,
		.thermalWarning(fl[4]), .pumpFault(fl[3]), .coilXOpen(fl[2]),
		.coilYOpen(fl[1]), .thermalShutdown(fl[0]), .xOvercurrent(xo),
		.yOvercurrent(yo), .dogTimeout(dto), .microstepPosition(msp),
		.angleMeasure(am), .speedAngleOutput(sa), .dogEventFlag(dog),
		.dogEnable(), .dogTimeSel(), .stepResolution(), .stepDivisor(div),
		.stepModeValid(smv), .halfStepComp(), .peakCurrentCode(),
		.peakCurrentMa(ma), .dirReverse(), .nxtFallingEdge(), .pwmDouble(pd),
		.pwmJitter(pj), .slopeSel(), .bridgeEnable(be), .sleepRequest(),
		.angleGainQuarter(), .angleHold(), .pwmModeSel(), .maskTimeSel(),
		.maskTimeCycles(mc), .dutyLimit75(), .dutyLimitPercent(dp),
		.compBridgeTimeSel(), .compBridgeCycles(cc));

	// System clock, 5 ns period
	always #2.5 clk = ~clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		m.xfer({3'b100, a, d}, 16, rd);
	endtask : wr

	task automatic rdChk(input logic [4:0] a, input logic [7:0] exp);
		m.xfer({3'b000, a, 8'h00}, 16, rd);
		chk(rd, exp);
	endtask : rdChk

	task automatic tally_and_finish;
		$display("errors %0d, checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// Watchdog against a hung handshake; tests need about 20 us
	initial begin
		#60000;
		num_errors++;
		tally_and_finish;
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		chk(ma, 13'h07a);
		for (int a = 4; a < 8; a++) rdChk(a[4:0], 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(5'h01, {i[2:0], {5{i[0]}}});
			chk(div, divs[i]);
			chk(smv, i != 7);
			chk(ma, i[0] ? 13'h128e : 13'h07a);
		end
		for (int i = 0; i < 4; i++) begin
			wr(5'h08, {2'b00, i[1:0], 1'b0, i[0], i[1:0]});
			chk(mc, cyc[i]);
			chk(cc, cyc[i]);
			chk(dp, i[0] ? 7'h4b : 7'h56);
		end
		wr(5'h02, 8'h08);
		chk({pd, pj}, 2'b10);
		wr(5'h02, 8'h04);
		chk({pd, pj}, 2'b01);
		m.xfer(16'h820c, 17, rd);
		chk({pd, pj}, 2'b01);
		@(posedge clk) am <= 8'hc8;
		wr(5'h03, 8'h80);
		chk(be, 1'b1);
		chk(sa, 8'h64);
		wr(5'h03, 8'ha0);
		chk(sa, 8'h32);
		wr(5'h03, 8'hb0);
		@(posedge clk) am <= 8'h40;
		repeat (4) @(posedge clk);
		chk(sa, 8'h32);
		wr(5'h03, 8'h20);
		chk({be, sa}, 9'h010);
		@(posedge clk) xo <= 4'ha;
		yo <= 4'h7;
		fl <= 5'h1d;
		msp <= 7'h15;
		repeat (6) @(posedge clk);
		chk(errOe, 1'b1);
		rdChk(5'h04, 8'he8);
		rdChk(5'h07, 8'h95);
		@(posedge clk) xo <= 4'h0;
		yo <= 4'h0;
		fl <= 5'h00;
		repeat (6) @(posedge clk);
		rdChk(5'h05, 8'h50);
		rdChk(5'h05, 8'h00);
		rdChk(5'h06, 8'h3c);
		chk(errOe, 1'b0);
		@(posedge clk) dto <= 1'b1;
		@(posedge clk) dto <= 1'b0;
		repeat (2) @(posedge clk);
		chk(dog, 1'b1);
		rdChk(5'h04, 8'h90); // Warm boot seen by master
		wr(5'h00, 8'h80);
		rdChk(5'h04, 8'h90);
		wr(5'h00, 8'h00);
		chk(dog, 1'b0);
		tally_and_finish;
	end
endmodule : test_stepper_reg_bank
